// >>> design/gml_top.sv
// Functional notes
// - Above charge level: charge mode, flag cleared
// - Below band then inside: start discharge settle timer
// - Above band then inside: start charge settle timer
// - Relax only after whole settle interval in band
// - Relaxation keeps discharge flag set
// - After 30 min relax, capture OCV when drift tiny
// - At or below minus discharge level: discharge, flag
// - Discharge current negative; level held as magnitude
// - Prior values first, running average after 500 s
// - Temperature change forces early running-average resimulation
// - Load kind 0 current model, 1 power
// - Status word mirrors load kind
// - Current model selection values 0 to 6
// - Power model selection values 0 to 6
// - Log discharge mean current, keep if >=500 s
// - Log discharge mean power, keep if >=500 s
module gml_top #(
  parameter int TICK_CYCLES = gml_pkg::SEC_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] mean_current,
  input wire logic [15:0] inst_current,
  input wire logic [15:0] cell_voltage,
  input wire logic temp_change,
  output logic discharge_flag,
  output logic [1:0] op_mode,
  output logic [31:0] sim_value,
  output logic sim_request,
  output logic ocv_capture,
  output logic [15:0] ocv_value
);
  typedef struct packed {
    logic awready, wready, bvalid;
    logic [1:0] bresp;
    logic arready, rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got, w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [15:0] dsg_lvl, chg_lvl, idle_lvl, dsg_settle;
    logic [7:0] chg_settle;
    logic [2:0] load_sel;
    logic load_kind;
    logic [15:0] user_cur, user_pwr, host_rate, design_cap, design_energy;
    logic [31:0] prior_cur, prior_pwr, tick_cnt;
    gml_pkg::gml_mode_t mode;
    logic dsg_flag;
    gml_pkg::gml_side_t side;
    logic settle_run;
    logic [15:0] settle_cnt, relax_secs;
    logic ocv_done, ocv_pulse;
    logic [15:0] prev_v, ocv_value;
    logic [31:0] dsg_secs;
    logic signed [47:0] sum_i;
    logic signed [63:0] sum_p;
    logic use_running;
    logic signed [31:0] lpf;
    logic [31:0] sim_value;
    logic sim_req;
  } gml_state_t;
  gml_state_t s, n;
  logic tick, in_band;
  logic signed [16:0] ci, chg_s, dsg_s, quit_s;
  logic signed [33:0] p_inst, p_mean;
  logic signed [47:0] p_filt, avg_i;
  logic signed [63:0] avg_p;
  logic [16:0] dv;
  logic drift_ok;
  logic [15:0] settle_limit;
  logic [31:0] wm;
  logic [5:0] widx;
  // Discharge arrives negative; levels are magnitudes, compared in 17 bits
  assign ci = {mean_current[15], mean_current};
  assign chg_s = {1'b0, s.chg_lvl};
  assign dsg_s = {1'b0, s.dsg_lvl};
  assign quit_s = {1'b0, s.idle_lvl};
  assign tick = (s.tick_cnt == 32'(TICK_CYCLES - 1));
  assign in_band = (ci <= quit_s) && (ci >= -quit_s);
  assign settle_limit = (s.side == gml_pkg::GML_SIDE_ABOVE) ? {8'h00, s.chg_settle} : s.dsg_settle;
  assign dv = (cell_voltage >= s.prev_v) ? 17'(cell_voltage - s.prev_v) : 17'(s.prev_v - cell_voltage);
  // Voltage is in mV, so only an unchanged reading meets the microvolt limit
  assign drift_ok = (32'(dv) * 32'(gml_pkg::UV_PER_MV)) < 32'(gml_pkg::DRIFT_LIMIT_UV);
  assign p_inst = ($signed({inst_current[15], inst_current}) * $signed({1'b0, cell_voltage}))
                  / 34'(gml_pkg::MILLI_SCALE);
  assign p_mean = (ci * $signed({1'b0, cell_voltage})) / 34'(gml_pkg::MILLI_SCALE);
  assign p_filt = (48'(s.lpf) * $signed({32'h0, cell_voltage})) / 48'(gml_pkg::MILLI_SCALE);
  assign widx = word_idx(s.waddr);
  // Wide dividers: area traded for a single-cycle running average
  assign avg_i = (s.dsg_secs != 32'h0) ? s.sum_i / $signed({16'h0, s.dsg_secs}) : 48'sh0;
  assign avg_p = (s.dsg_secs != 32'h0) ? s.sum_p / $signed({32'h0, s.dsg_secs}) : 64'sh0;
  function automatic logic [5:0] word_idx(input logic [7:0] a);
    return a[gml_pkg::ADDR_W-1:gml_pkg::ADDR_LSB];
  endfunction : word_idx
  function automatic logic is_mapped(input logic [5:0] idx);
    return (idx < gml_pkg::IDX_LOAD_CFG) ? !idx[0] : (idx <= gml_pkg::IDX_OCV);
  endfunction : is_mapped
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i*8 +: 8] = b[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
    return r;
  endfunction : merge_bytes
  function automatic logic [31:0] read_word(input logic [5:0] idx);
    logic [31:0] r;
    r = 32'h0;
    unique case (idx)
      gml_pkg::IDX_DSG_ENTRY: r = {16'h0, s.dsg_lvl};
      gml_pkg::IDX_CHG_ENTRY: r = {16'h0, s.chg_lvl};
      gml_pkg::IDX_IDLE_BAND: r = {16'h0, s.idle_lvl};
      gml_pkg::IDX_DSG_SETTLE: r = {16'h0, s.dsg_settle};
      gml_pkg::IDX_CHG_SETTLE: r = {24'h0, s.chg_settle};
      gml_pkg::IDX_LOAD_CFG: begin
        r[gml_pkg::LCFG_SEL_LSB +: 3] = s.load_sel;
        r[gml_pkg::LCFG_KIND_BIT] = s.load_kind;
      end
      gml_pkg::IDX_USER_CUR: r = {16'h0, s.user_cur};
      gml_pkg::IDX_USER_PWR: r = {16'h0, s.user_pwr};
      gml_pkg::IDX_HOST_RATE: r = {16'h0, s.host_rate};
      gml_pkg::IDX_DESIGN_CAP: r = {16'h0, s.design_cap};
      gml_pkg::IDX_DESIGN_ENERGY: r = {16'h0, s.design_energy};
      gml_pkg::IDX_PRIOR_CUR: r = s.prior_cur;
      gml_pkg::IDX_PRIOR_PWR: r = s.prior_pwr;
      gml_pkg::IDX_STATUS: begin
        r[gml_pkg::ST_MODE_LSB +: 2] = s.mode;
        r[gml_pkg::ST_DSG_BIT] = s.dsg_flag;
        r[gml_pkg::ST_KIND_BIT] = s.load_kind;
        r[gml_pkg::ST_RUNNING_BIT] = s.use_running;
        r[gml_pkg::ST_OCV_BIT] = s.ocv_done;
      end
      gml_pkg::IDX_SIM_VALUE: r = s.sim_value;
      gml_pkg::IDX_OCV: r = {16'h0, s.ocv_value};
      default: r = 32'h0;
    endcase
    return r;
  endfunction : read_word
  // Before the running average is valid the prior-run value stands in
  function automatic logic [31:0] pick_load(input logic kind, input logic [2:0] sel);
    logic [31:0] r;
    unique case (sel)
      gml_pkg::SEL_PRIOR: r = kind ? s.prior_pwr : s.prior_cur;
      gml_pkg::SEL_PRESENT: r = s.use_running ? (kind ? avg_p[31:0] : avg_i[31:0])
                                              : (kind ? s.prior_pwr : s.prior_cur);
      gml_pkg::SEL_MEAN: r = kind ? p_mean[31:0] : 32'(ci);
      gml_pkg::SEL_FILTERED: r = kind ? p_filt[31:0] : s.lpf;
      gml_pkg::SEL_DESIGN_RATE: r = kind ? -32'(s.design_energy / 16'(gml_pkg::RATE_DIV))
                                         : -32'(s.design_cap / 16'(gml_pkg::RATE_DIV));
      gml_pkg::SEL_HOST_RATE: r = 32'($signed(s.host_rate));
      gml_pkg::SEL_USER: r = kind ? {16'h0, s.user_pwr} : {16'h0, s.user_cur};
      default: r = kind ? s.prior_pwr : s.prior_cur;
    endcase
    return r;
  endfunction : pick_load

  always_comb begin
    n = s;
    wm = merge_bytes(read_word(widx), s.wdata, s.wstrb);
    n.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;
    n.ocv_pulse = 1'b0;
    n.sim_req = 1'b0;
    if (s.awready && s_axi_awvalid) begin
      n.aw_got = 1'b1;
      n.awready = 1'b0;
      n.waddr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      n.w_got = 1'b1;
      n.wready = 1'b0;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = is_mapped(widx) ? gml_pkg::RESP_OKAY : gml_pkg::RESP_SLVERR;
      unique case (widx)
        gml_pkg::IDX_DSG_ENTRY: n.dsg_lvl = wm[15:0];
        gml_pkg::IDX_CHG_ENTRY: n.chg_lvl = wm[15:0];
        gml_pkg::IDX_IDLE_BAND: n.idle_lvl = wm[15:0];
        gml_pkg::IDX_DSG_SETTLE: n.dsg_settle = wm[15:0];
        gml_pkg::IDX_CHG_SETTLE: n.chg_settle = wm[7:0];
        gml_pkg::IDX_LOAD_CFG: begin
          n.load_sel = wm[gml_pkg::LCFG_SEL_LSB +: 3];
          n.load_kind = wm[gml_pkg::LCFG_KIND_BIT];
        end
        gml_pkg::IDX_USER_CUR: n.user_cur = wm[15:0];
        gml_pkg::IDX_USER_PWR: n.user_pwr = wm[15:0];
        gml_pkg::IDX_HOST_RATE: n.host_rate = wm[15:0];
        gml_pkg::IDX_DESIGN_CAP: n.design_cap = wm[15:0];
        gml_pkg::IDX_DESIGN_ENERGY: n.design_energy = wm[15:0];
        gml_pkg::IDX_PRIOR_CUR: n.prior_cur = wm;
        gml_pkg::IDX_PRIOR_PWR: n.prior_pwr = wm;
        default: n.bresp = n.bresp;
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (s.arready && s_axi_arvalid) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rdata = read_word(word_idx(s_axi_araddr));
      n.rresp = is_mapped(word_idx(s_axi_araddr)) ? gml_pkg::RESP_OKAY : gml_pkg::RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (tick) begin
      n.prev_v = cell_voltage;
      n.lpf = s.lpf + 32'((32'(ci) - s.lpf) / 32'(gml_pkg::LPF_TAU_SEC));
      if (ci > chg_s) begin
        n.mode = gml_pkg::GML_CHARGE;
        n.side = gml_pkg::GML_SIDE_ABOVE;
        n.settle_run = 1'b0;
      end else if (ci <= -dsg_s) begin
        n.mode = gml_pkg::GML_DISCHARGE;
        n.side = gml_pkg::GML_SIDE_BELOW;
        n.settle_run = 1'b0;
      end else if (ci > quit_s) begin
        n.side = gml_pkg::GML_SIDE_ABOVE;
        n.settle_run = 1'b0;
      end else if (ci < -quit_s) begin
        n.side = gml_pkg::GML_SIDE_BELOW;
        n.settle_run = 1'b0;
      end else if (s.side != gml_pkg::GML_SIDE_NONE) begin
        n.settle_run = 1'b1;
        n.settle_cnt = s.settle_run ? s.settle_cnt + 16'h1 : 16'h0;
        if (s.settle_run && (s.settle_cnt + 16'h1 >= settle_limit)) begin
          n.mode = gml_pkg::GML_RELAX;
          n.side = gml_pkg::GML_SIDE_NONE;
          n.settle_run = 1'b0;
        end
      end
      if (s.mode == gml_pkg::GML_RELAX && n.mode == gml_pkg::GML_RELAX) begin
        n.relax_secs = (s.relax_secs != 16'hffff) ? s.relax_secs + 16'h1 : s.relax_secs;
        if (s.relax_secs >= gml_pkg::RELAX_OCV_WAIT_S && !s.ocv_done && drift_ok) begin
          n.ocv_value = cell_voltage;
          n.ocv_pulse = 1'b1;
          n.ocv_done = 1'b1;
        end
      end else if (n.mode == gml_pkg::GML_RELAX) begin
        n.relax_secs = 16'h0;
        n.ocv_done = 1'b0;
      end
      if (s.mode == gml_pkg::GML_DISCHARGE) begin
        n.dsg_secs = s.dsg_secs + 32'h1;
        n.sum_i = s.sum_i + 48'(ci);
        n.sum_p = s.sum_p + 64'(p_inst);
        if (n.dsg_secs == gml_pkg::RESIM_POINT) begin
          n.use_running = 1'b1;
          n.sim_req = 1'b1;
        end
      end
      if (n.mode == gml_pkg::GML_DISCHARGE && s.mode != gml_pkg::GML_DISCHARGE) begin
        n.dsg_secs = 32'h0;
        n.sum_i = '0;
        n.sum_p = '0;
        n.use_running = 1'b0;
        n.sim_req = 1'b1;
      end
      if (s.mode == gml_pkg::GML_DISCHARGE && n.mode != gml_pkg::GML_DISCHARGE) begin
        n.use_running = 1'b0;
        // Short discharges are dropped so a blip cannot spoil the history
        if (s.dsg_secs >= gml_pkg::RESIM_POINT) begin
          n.prior_cur = avg_i[31:0];
          n.prior_pwr = avg_p[31:0];
        end
      end
    end
    if (temp_change && s.mode == gml_pkg::GML_DISCHARGE && n.mode == gml_pkg::GML_DISCHARGE && !s.use_running) begin
      n.use_running = 1'b1;
      n.sim_req = 1'b1;
    end
    // Flag follows the mode, so it only moves when the mode does
    n.dsg_flag = (n.mode != gml_pkg::GML_CHARGE);
    n.sim_value = pick_load(s.load_kind, s.load_sel);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.dsg_lvl <= gml_pkg::RST_DSG_ENTRY;
      s.chg_lvl <= gml_pkg::RST_CHG_ENTRY;
      s.idle_lvl <= gml_pkg::RST_IDLE_BAND;
      s.dsg_settle <= gml_pkg::RST_DSG_SETTLE;
      s.chg_settle <= gml_pkg::RST_CHG_SETTLE;
      s.load_sel <= gml_pkg::RST_LOAD_SEL;
      s.design_cap <= gml_pkg::RST_DESIGN_CAP;
      s.design_energy <= gml_pkg::RST_DESIGN_ENERGY;
      s.prior_cur <= gml_pkg::RST_PRIOR_CUR;
      s.prior_pwr <= gml_pkg::RST_PRIOR_PWR;
      s.mode <= gml_pkg::GML_RELAX;
      s.dsg_flag <= 1'b1;
    end else begin
      s <= n;
    end
  end
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign discharge_flag = s.dsg_flag;
  assign op_mode = s.mode;
  assign sim_value = s.sim_value;
  assign sim_request = s.sim_req;
  assign ocv_capture = s.ocv_pulse;
  assign ocv_value = s.ocv_value;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_chg_entry;
    tick && (ci > chg_s) |=> (op_mode == gml_pkg::GML_CHARGE) && !discharge_flag;
  endproperty
  a_chg_entry: assert property (p_chg_entry) else $error("charge entry missed");
  property p_dsg_entry;
    tick && (ci <= -dsg_s) && !(ci > chg_s) |=> (op_mode == gml_pkg::GML_DISCHARGE) && discharge_flag;
  endproperty
  a_dsg_entry: assert property (p_dsg_entry) else $error("discharge entry missed");
  property p_relax_flag;
    op_mode == gml_pkg::GML_RELAX |-> discharge_flag;
  endproperty
  a_relax_flag: assert property (p_relax_flag) else $error("flag low in relaxation");
  property p_dsg_timer;
    tick && in_band && s.side == gml_pkg::GML_SIDE_BELOW && !s.settle_run |=> s.settle_run && s.settle_cnt == 16'h0;
  endproperty
  a_dsg_timer: assert property (p_dsg_timer) else $error("discharge settle timer not started");
  property p_chg_timer;
    tick && in_band && s.side == gml_pkg::GML_SIDE_ABOVE && !s.settle_run |=> s.settle_run && s.settle_cnt == 16'h0;
  endproperty
  a_chg_timer: assert property (p_chg_timer) else $error("charge settle timer not started");
  property p_relax_entry;
    tick && in_band && s.settle_run && (s.settle_cnt + 16'h1 >= settle_limit) |=> op_mode == gml_pkg::GML_RELAX;
  endproperty
  a_relax_entry: assert property (p_relax_entry) else $error("relaxation not entered");
  property p_cancel;
    tick && !in_band && (ci <= chg_s) && (ci > -dsg_s) |=> !s.settle_run && $stable(op_mode);
  endproperty
  a_cancel: assert property (p_cancel) else $error("settle timer not cancelled");
  property p_hold;
    !tick |=> $stable(op_mode) && $stable(discharge_flag);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved off tick");
  property p_ocv;
    ocv_capture |-> op_mode == gml_pkg::GML_RELAX && s.relax_secs > gml_pkg::RELAX_OCV_WAIT_S;
  endproperty
  a_ocv: assert property (p_ocv) else $error("early ocv capture");
  property p_running;
    tick && s.mode == gml_pkg::GML_DISCHARGE && ci <= -dsg_s && s.dsg_secs == gml_pkg::RESIM_POINT - 32'h1
      |=> s.use_running && sim_request;
  endproperty
  a_running: assert property (p_running) else $error("no resimulation at 500 s");
  property p_short_dsg;
    tick && s.mode == gml_pkg::GML_DISCHARGE && n.mode != gml_pkg::GML_DISCHARGE
      && s.dsg_secs < gml_pkg::RESIM_POINT && !(s.aw_got && s.w_got) |=> $stable(s.prior_cur);
  endproperty
  a_short_dsg: assert property (p_short_dsg) else $error("short discharge stored");
  c_charge: cover property (tick && ci > chg_s ##1 op_mode == gml_pkg::GML_CHARGE);
  c_relax: cover property ($rose(op_mode == gml_pkg::GML_RELAX));
  c_discharge: cover property ($rose(op_mode == gml_pkg::GML_DISCHARGE));
  c_ocv: cover property (ocv_capture);
endmodule : gml_top

// >>> design/gml_pkg.sv
package gml_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SEC_NS = 1000000000;
  localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
  localparam int RELAX_OCV_WAIT_MIN = 30;
  localparam logic [15:0] RELAX_OCV_WAIT_S = 16'(RELAX_OCV_WAIT_MIN * 60);
  localparam int DRIFT_LIMIT_UV = 1;
  localparam int UV_PER_MV = 1000;
  localparam int MILLI_SCALE = 1000;
  localparam int RESIM_POINT_SEC = 500;
  localparam logic [31:0] RESIM_POINT = 32'(RESIM_POINT_SEC);
  localparam int LPF_TAU_SEC = 14;
  localparam int RATE_DIV = 5;
  localparam int ADDR_W = 8;
  localparam int ADDR_LSB = 2;
  localparam logic [5:0] IDX_DSG_ENTRY = 6'h00;
  localparam logic [5:0] IDX_CHG_ENTRY = 6'h02;
  localparam logic [5:0] IDX_IDLE_BAND = 6'h04;
  localparam logic [5:0] IDX_DSG_SETTLE = 6'h06;
  localparam logic [5:0] IDX_CHG_SETTLE = 6'h08;
  localparam logic [5:0] IDX_LOAD_CFG = 6'h0a;
  localparam logic [5:0] IDX_USER_CUR = 6'h0b;
  localparam logic [5:0] IDX_USER_PWR = 6'h0c;
  localparam logic [5:0] IDX_HOST_RATE = 6'h0d;
  localparam logic [5:0] IDX_DESIGN_CAP = 6'h0e;
  localparam logic [5:0] IDX_DESIGN_ENERGY = 6'h0f;
  localparam logic [5:0] IDX_PRIOR_CUR = 6'h10;
  localparam logic [5:0] IDX_PRIOR_PWR = 6'h11;
  localparam logic [5:0] IDX_STATUS = 6'h12;
  localparam logic [5:0] IDX_SIM_VALUE = 6'h13;
  localparam logic [5:0] IDX_OCV = 6'h14;
  localparam logic [15:0] RST_DSG_ENTRY = 16'h003c;
  localparam logic [15:0] RST_CHG_ENTRY = 16'h004b;
  localparam logic [15:0] RST_IDLE_BAND = 16'h0028;
  localparam logic [15:0] RST_DSG_SETTLE = 16'h003c;
  localparam logic [7:0] RST_CHG_SETTLE = 8'h3c;
  localparam logic [2:0] RST_LOAD_SEL = 3'h1;
  localparam logic [15:0] RST_DESIGN_CAP = 16'h03e8;
  localparam logic [15:0] RST_DESIGN_ENERGY = 16'h0ed8;
  localparam logic [31:0] RST_PRIOR_CUR = 32'hfffffed5;
  localparam logic [31:0] RST_PRIOR_PWR = 32'hfffffb95;
  localparam int LCFG_SEL_LSB = 0;
  localparam int LCFG_KIND_BIT = 4;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_DSG_BIT = 2;
  localparam int ST_KIND_BIT = 3;
  localparam int ST_RUNNING_BIT = 4;
  localparam int ST_OCV_BIT = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {GML_CHARGE, GML_RELAX, GML_DISCHARGE} gml_mode_t;
  typedef enum logic [1:0] {GML_SIDE_NONE, GML_SIDE_ABOVE, GML_SIDE_BELOW} gml_side_t;
  localparam logic [2:0] SEL_PRIOR = 3'h0;
  localparam logic [2:0] SEL_PRESENT = 3'h1;
  localparam logic [2:0] SEL_MEAN = 3'h2;
  localparam logic [2:0] SEL_FILTERED = 3'h3;
  localparam logic [2:0] SEL_DESIGN_RATE = 3'h4;
  localparam logic [2:0] SEL_HOST_RATE = 3'h5;
  localparam logic [2:0] SEL_USER = 3'h6;
endpackage : gml_pkg

// >>> testbench/gml_cell_model.sv
module gml_cell_model (
  input wire logic sys_clk,
  input wire logic [15:0] load_ma,
  output logic [15:0] mean_current,
  output logic [15:0] inst_current,
  output logic [15:0] cell_voltage
);
  timeunit 1ns;
  timeprecision 1ps;
  // Flat rest voltage lets the drift test settle at once
  always_ff @(posedge sys_clk) begin
    mean_current <= load_ma;
    inst_current <= load_ma;
    cell_voltage <= 16'h0ed8;
  end
endmodule : gml_cell_model

// >>> testbench/gauge_mode_and_load_model_tb.sv
module gauge_mode_and_load_model_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [33:0] v; logic [33:0] m; string n;} gml_exp_t;
  localparam logic [33:0] ALL = 34'h3ffffffff;
  gml_exp_t q[$];
  int errors = 0;
  int checks = 0;
  int sreqs = 0;
  int ocaps = 0;
  int sl[4] = '{0, 4, 5, 6};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, temp_change = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, h = 32'h00014dcb, e;
  logic [15:0] load_ma = 16'h0;
  logic awready, wready, bvalid, arready, rvalid, dflag, sreq, ocap;
  logic [1:0] bresp, rresp, op_mode;
  logic [31:0] rdata, sim_value;
  logic [15:0] mcur, icur, volt, ocv_value;

  always #2.5 sys_clk = ~sys_clk;

  gml_cell_model i_cell (.sys_clk(sys_clk), .load_ma(load_ma), .mean_current(mcur), .inst_current(icur),
    .cell_voltage(volt));

  gml_top #(.TICK_CYCLES(4)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mean_current(mcur), .inst_current(icur), .cell_voltage(volt),
    .temp_change(temp_change), .discharge_flag(dflag), .op_mode(op_mode), .sim_value(sim_value),
    .sim_request(sreq), .ocv_capture(ocap), .ocv_value(ocv_value));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [33:0] ok(input logic [31:0] d);
    return {gml_pkg::RESP_OKAY, d};
  endfunction : ok

  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] x);
    checks++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic final_report;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= {i, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  // Note the expectation first, the monitor pops it on the data beat
  task automatic rd(input logic [5:0] i, input logic [33:0] x, input logic [33:0] m, input string n);
    q.push_back('{x, m, n});
    @(posedge sys_clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  task automatic st(input logic [1:0] md, input string n);
    rd(gml_pkg::IDX_STATUS, ok({29'h0, md != 2'h0, md}), 34'h300000007, n);
  endtask : st

  task automatic tk(input int n);
    repeat (n * 4) @(posedge sys_clk);
  endtask : tk

  task automatic cur(input logic [15:0] v, input int n);
    @(posedge sys_clk);
    load_ma <= v;
    tk(n);
  endtask : cur

  always @(posedge sys_clk) begin
    if (rvalid && rready && q.size() > 0) begin
      gml_exp_t x;
      x = q.pop_front();
      chk(x.n, {rresp, rdata} & x.m, x.v & x.m);
    end
  end

  always @(posedge sys_clk) begin
    if (rst_n && sreq) sreqs++;
    if (rst_n && ocap) ocaps++;
  end

  initial begin
    #200us;
    errors++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(gml_pkg::IDX_DSG_ENTRY, ok(32'h3c), ALL, "dsg_entry");
    rd(gml_pkg::IDX_CHG_ENTRY, ok(32'h4b), ALL, "chg_entry");
    rd(gml_pkg::IDX_IDLE_BAND, ok(32'h28), ALL, "idle_band");
    rd(gml_pkg::IDX_DSG_SETTLE, ok(32'h3c), ALL, "dsg_settle");
    rd(gml_pkg::IDX_CHG_SETTLE, ok(32'h3c), ALL, "chg_settle");
    rd(6'h3f, {gml_pkg::RESP_SLVERR, 32'h0}, ALL, "unmapped");
    st(2'h1, "reset mode");
    // Short settle times keep the run brief; band stays below both entry levels
    wr(gml_pkg::IDX_CHG_SETTLE, 32'h2);
    wr(gml_pkg::IDX_DSG_SETTLE, 32'h5);
    rd(gml_pkg::IDX_DSG_SETTLE, ok(32'h5), ALL, "dsg_settle wr");
    wr(gml_pkg::IDX_PRIOR_CUR, 32'hffffff38);
    cur(16'd75, 3);
    st(2'h1, "at charge level");
    cur(16'd76, 2);
    st(2'h0, "charge");
    cur(16'hffc5, 2);
    st(2'h0, "near dsg level");
    cur(16'hffc4, 2);
    st(2'h2, "discharge");
    @(posedge sys_clk);
    temp_change <= 1'b1;
    @(posedge sys_clk);
    temp_change <= 1'b0;
    rd(gml_pkg::IDX_STATUS, ok(32'h10), 34'h300000010, "early resim");
    cur(16'h0000, 3);
    st(2'h2, "settling");
    cur(16'hffce, 2);
    st(2'h2, "band left");
    cur(16'h0000, 4);
    st(2'h2, "rearmed");
    tk(4);
    st(2'h1, "relaxed");
    rd(gml_pkg::IDX_PRIOR_CUR, ok(32'hffffff38), ALL, "short run");
    cur(16'd100, 2);
    cur(16'h0000, 6);
    st(2'h1, "chg relaxed");
    cur(16'hff9c, 3);
    rd(gml_pkg::IDX_STATUS, ok(32'h0), 34'h300000010, "prior in use");
    rd(gml_pkg::IDX_SIM_VALUE, ok(32'hffffff38), ALL, "sim prior");
    tk(505);
    rd(gml_pkg::IDX_STATUS, ok(32'h10), 34'h300000010, "running");
    rd(gml_pkg::IDX_SIM_VALUE, ok(32'hffffff9c), ALL, "sim running");
    cur(16'd100, 2);
    rd(gml_pkg::IDX_PRIOR_CUR, ok(32'hffffff9c), ALL, "prior cur");
    rd(gml_pkg::IDX_PRIOR_PWR, ok(32'hfffffe84), ALL, "prior pwr");
    cur(16'h0000, 4);
    tk(1805);
    rd(gml_pkg::IDX_OCV, ok(32'h0ed8), ALL, "ocv");
    rd(gml_pkg::IDX_STATUS, ok(32'h25), 34'h300000027, "ocv taken");
    h = lfsr(h);
    wr(gml_pkg::IDX_HOST_RATE, {16'h0, h[15:0]});
    wr(gml_pkg::IDX_USER_CUR, {17'h0, h[30:16]});
    wr(gml_pkg::IDX_USER_PWR, {17'h0, h[30:16]});
    for (int k = 0; k < 2; k++) begin
      for (int s = 0; s < 4; s++) begin
        wr(gml_pkg::IDX_LOAD_CFG, {27'h0, k[0], 1'b0, 3'(sl[s])});
        e = sl[s] == 0 ? (k[0] ? 32'hfffffe84 : 32'hffffff9c) :
            sl[s] == 4 ? (k[0] ? 32'hfffffd08 : 32'hffffff38) :
            sl[s] == 5 ? {{16{h[15]}}, h[15:0]} : {17'h0, h[30:16]};
        rd(gml_pkg::IDX_SIM_VALUE, ok(e), ALL, "load value");
      end
      rd(gml_pkg::IDX_STATUS, ok({28'h0, k[0], 3'h0}), 34'h300000008, "kind");
    end
    chk("sim pin", {2'h0, sim_value}, {2'h0, e});
    chk("mode pins", {31'h0, dflag, op_mode}, {31'h0, 1'b1, 2'h1});
    chk("ocv pin", {18'h0, ocv_value}, {18'h0, 16'h0ed8});
    chk("ocv pulses", 34'(ocaps), 34'h1);
    chk("resim pulses", 34'(sreqs), 34'h4);
    final_report();
  end
endmodule : gauge_mode_and_load_model_tb
